// file: core/supply_supervisor_reset_watchdog.sv
/*
 * supply supervisor: reset sequencing, early warning, watchdog,
 * chip-select gating and overvoltage flag.
 * assumes comparator decisions arrive as levels; ce_in_n is synchronous.
 */
module supply_supervisor_reset_watchdog #(
    parameter logic [sup_pkg::TW-1:0] STRETCH_TICKS = sup_pkg::STRETCH_TICKS_DEF,
    parameter logic [sup_pkg::TW-1:0] WD_TICKS = sup_pkg::WD_TICKS_DEF,
    parameter logic [sup_pkg::TW-1:0] WD_ALT_TICKS = sup_pkg::WD_ALT_TICKS_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // supply comparator decisions, high = condition true
    input wire logic mode_ext_sense,
    input wire logic vcc_below_reset,
    input wire logic vcc_below_early_warning_n,
    input wire logic ext_reset_below,
    input wire logic early_warning_n_sense_in,
    // manual reset, high = above threshold
    input wire logic manual_reset_n,
    // watchdog
    input wire logic wd_activity_in,
    input wire logic wd_period_select,
    // overvoltage, high = sense above threshold
    input wire logic overvoltage_sense,
    // chip-select pass path
    input wire logic ce_in_n,
    output logic ce_out_n,
    output logic ce_in_float,
    // processor outputs
    output logic reset_n,
    output logic reset_out,
    output logic early_warning_n,
    output logic overvoltage_flag_n,
    output logic wd_fault_n,
    output logic wd_pulse_n
);
    import sup_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers and time base
    // ------------------------------------------------------------
    logic [SY_W-1:0] sy;
    logic [TICK_W-1:0] tick_cnt_ff;
    logic tick;

    sync2 #(.W(SY_W), .RST_VAL(SYNC_RST)) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .d({overvoltage_sense, wd_activity_in, early_warning_n_sense_in, ext_reset_below,
            vcc_below_early_warning_n, vcc_below_reset, mode_ext_sense, manual_reset_n}),
        .q(sy)
    );

    // free-running prescaler shared by every timer
    assign tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            tick_cnt_ff <= '0;
        else
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
    end

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    timer_if mr_if ();
    timer_if st_if ();
    timer_if wd_if ();
    timer_if pl_if ();
    timer_if ce_if ();

    tick_timer u_mr (.sys_clk(sys_clk), .srst(srst), .tick(tick), .t(mr_if));
    tick_timer u_st (.sys_clk(sys_clk), .srst(srst), .tick(tick), .t(st_if));
    tick_timer u_wd (.sys_clk(sys_clk), .srst(srst), .tick(tick), .t(wd_if));
    tick_timer u_pl (.sys_clk(sys_clk), .srst(srst), .tick(tick), .t(pl_if));
    tick_timer u_ce (.sys_clk(sys_clk), .srst(srst), .tick(tick), .t(ce_if));

    // ------------------------------------------------------------
    // threshold selection and manual reset
    // ------------------------------------------------------------
    logic mode_ext;
    logic supply_low;
    logic warn_low;
    logic mr_active;
    logic rst_cond;

    assign mode_ext = sy[SY_MODE];
    assign supply_low = mode_ext ? sy[SY_XRST] : sy[SY_VRST];
    // in internal mode the reset trip also forces the warning, so it never lags reset there; external mode uses the warning sense alone
    assign warn_low = mode_ext ? sy[SY_XLL] : (sy[SY_VLL] | sy[SY_VRST]);

    // short glitches under the latency are rejected, 25us always passes
    assign mr_if.clr = sy[SY_MR];
    assign mr_if.en = 1'b1;
    assign mr_if.limit = MR_LAT_TICKS;
    assign mr_active = mr_if.done;
    assign rst_cond = supply_low | mr_active;

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    rst_state_t state_ff;
    rst_state_t nxt_state;
    logic rst_active;
    logic rst_rise;

    // stretch counter only runs once every cause has gone
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            RS_RUN:
                if (rst_cond)
                    nxt_state = RS_ACTIVE;
            RS_ACTIVE:
                if (!rst_cond)
                    nxt_state = RS_STRETCH;
            RS_STRETCH:
                if (rst_cond)
                    nxt_state = RS_ACTIVE;
                else if (st_if.done)
                    nxt_state = RS_RUN;
            default:
                nxt_state = RS_ACTIVE;
        endcase
    end

    assign st_if.clr = (state_ff != RS_STRETCH);
    assign st_if.en = (state_ff == RS_STRETCH);
    assign st_if.limit = STRETCH_TICKS;
    assign rst_active = (state_ff != RS_RUN);
    assign rst_rise = (state_ff == RS_RUN) && (nxt_state != RS_RUN);

    // power-up starts in reset and stretches
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            state_ff <= RS_ACTIVE;
        else
            state_ff <= nxt_state;
    end

    assign reset_n = !rst_active;
    assign reset_out = rst_active;

    // ------------------------------------------------------------
    // early warning and overvoltage flags
    // ------------------------------------------------------------
    logic warn_n_ff;
    logic ovf_n_ff;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            warn_n_ff <= 1'b1;
            ovf_n_ff <= 1'b1;
        end
        else
        begin
            warn_n_ff <= !warn_low;
            ovf_n_ff <= !sy[SY_OV];
        end
    end

    assign early_warning_n = warn_n_ff;
    assign overvoltage_flag_n = ovf_n_ff;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic wdi_d_ff;
    logic wdi_edge;
    logic wd_timeout;
    logic fault_pend_ff;
    logic fault_n_ff;
    logic pulse_n_ff;
    logic nxt_fault_n;
    logic nxt_pulse_n;

    // pulses of 100ns span ten clocks, so both edges are seen
    assign wdi_edge = sy[SY_WDI] ^ wdi_d_ff;
    assign wd_if.clr = rst_active | wdi_edge | wd_if.done;
    assign wd_if.en = 1'b1;
    assign wd_if.limit = wd_period_select ? WD_TICKS : WD_ALT_TICKS;
    assign wd_timeout = wd_if.done && !rst_active;

    assign pl_if.clr = rst_active | wd_timeout;
    assign pl_if.en = !pulse_n_ff;
    assign pl_if.limit = PULSE_TICKS;

    // fault set wins over an activity edge in the same cycle
    assign nxt_pulse_n = rst_active ? 1'b1 :
                         (wd_timeout ? 1'b0 : (pl_if.done ? 1'b1 : pulse_n_ff));
    assign nxt_fault_n = rst_active ? 1'b1 :
                         (fault_pend_ff ? 1'b0 : (wdi_edge ? 1'b1 : fault_n_ff));

    // fault falls one clock after the pulse falls
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            wdi_d_ff <= 1'b0;
            fault_pend_ff <= 1'b0;
            fault_n_ff <= 1'b1;
            pulse_n_ff <= 1'b1;
        end
        else
        begin
            wdi_d_ff <= sy[SY_WDI];
            fault_pend_ff <= wd_timeout;
            fault_n_ff <= nxt_fault_n;
            pulse_n_ff <= nxt_pulse_n;
        end
    end

    assign wd_fault_n = fault_n_ff;
    assign wd_pulse_n = pulse_n_ff;

    // ------------------------------------------------------------
    // chip-select gating
    // ------------------------------------------------------------
    logic hold_ff;
    logic nxt_hold;
    logic pass_en;

    // lets a write in flight finish, bounded by the hold timer
    assign nxt_hold = (rst_rise && !ce_in_n) ? 1'b1 :
                      ((ce_in_n || ce_if.done || !rst_active) ? 1'b0 : hold_ff);
    assign ce_if.clr = !hold_ff;
    assign ce_if.en = hold_ff;
    assign ce_if.limit = CE_HOLD_TICKS;
    assign pass_en = !rst_active || hold_ff;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            hold_ff <= 1'b0;
        else
            hold_ff <= nxt_hold;
    end

    // pass path is combinational; disabled means pulled high
    assign ce_out_n = pass_en ? ce_in_n : 1'b1;
    assign ce_in_float = !pass_en;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [11:0] mr_low_cyc_ff;

    // only read by the manual reset check
    always_ff @(posedge sys_clk)
    begin
        if (srst || sy[SY_MR])
            mr_low_cyc_ff <= '0;
        else if (mr_low_cyc_ff != 12'hfff)
            mr_low_cyc_ff <= mr_low_cyc_ff + 1'b1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_mr_min_low: assert property ((mr_low_cyc_ff >= MR_MIN_CYC) |-> !reset_n)
        else $error("manual reset held past minimum without reset");
    a_mr_holds: assert property (mr_active |=> rst_active && state_ff != RS_RUN)
        else $error("reset released while manual reset active");
    a_supply_low: assert property (supply_low |=> !reset_n)
        else $error("supply low without reset");
    a_ext_mode: assert property (mode_ext && sy[SY_XRST] |=> !reset_n)
        else $error("external reset sense ignored");
    a_warn_first: assert property (!mode_ext && sy[SY_VRST] |=> !early_warning_n)
        else $error("reset without early warning");
    a_stretch_done: assert property ($rose(reset_n) |->
        $past(st_if.done) && !$past(rst_cond))
        else $error("reset released before stretch ended");
    a_wd_forced: assert property (rst_active |=> wd_fault_n && wd_pulse_n)
        else $error("watchdog outputs not forced high in reset");
    a_ce_blocked: assert property (rst_active && !hold_ff |-> ce_out_n && ce_in_float)
        else $error("chip-select passed during reset");
    a_rst_pair: assert property (reset_out == !reset_n)
        else $error("reset outputs not complementary");
    a_ov_flag: assert property (sy[SY_OV] |=> !overvoltage_flag_n)
        else $error("overvoltage flag missed");
    a_wd_sequence: assert property (wd_timeout |=> !wd_pulse_n ##1 !wd_fault_n)
        else $error("watchdog timeout outputs out of order");
    a_pulse_hold: assert property (!wd_pulse_n && !pl_if.done && !rst_active |=>
        !wd_pulse_n)
        else $error("watchdog pulse ended before its width");
    a_fault_hold: assert property (!wd_fault_n && !wdi_edge && !rst_active |=>
        !wd_fault_n)
        else $error("fault released without activity");
    a_wdi_restart: assert property (wdi_edge |=> !wd_timeout)
        else $error("watchdog not restarted by activity");
    a_ce_follow: assert property (pass_en |-> ce_out_n == ce_in_n)
        else $error("chip-select not following input");

    c_mr_reset: cover property (mr_active ##1 rst_active);
    c_wd_timeout: cover property (wd_timeout ##2 !wd_fault_n);
    c_ce_hold: cover property (rst_rise && !ce_in_n ##1 hold_ff);
    c_release: cover property ($rose(reset_n));
    c_ext_reset: cover property (mode_ext && sy[SY_XRST] ##1 rst_active);
endmodule

// file: core/sup_pkg.sv
/*
 * constants, reset values and state encoding for the supply supervisor.
 * assumes a 100 MHz sys_clk and comparator decisions that arrive as logic levels.
 */
package sup_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int TICK_W = 7;
    localparam int TW = 24; // width of every timeout counter, in ticks

    // ------------------------------------------------------------
    // documented times, in ns
    // ------------------------------------------------------------
    localparam int MR_LAT_NS = 12000;
    localparam int MR_MIN_NS = 25000;
    localparam int STRETCH_NS = 200000000;
    localparam int WD_NS = 1600000000;
    localparam int PULSE_NS = 1700000;
    localparam int CE_HOLD_NS = 15000;
    localparam int WDI_PULSE_NS = 100;

    // ------------------------------------------------------------
    // derived counts
    // ------------------------------------------------------------
    localparam logic [TW-1:0] MR_LAT_TICKS = TW'(MR_LAT_NS / TICK_NS);
    localparam logic [TW-1:0] STRETCH_TICKS_DEF = TW'(STRETCH_NS / TICK_NS);
    localparam logic [TW-1:0] WD_TICKS_DEF = TW'(WD_NS / TICK_NS);
    localparam logic [TW-1:0] WD_ALT_TICKS_DEF = TW'(800000); // plain default, alternate period
    localparam logic [TW-1:0] PULSE_TICKS = TW'(PULSE_NS / TICK_NS);
    localparam logic [TW-1:0] CE_HOLD_TICKS = TW'(CE_HOLD_NS / TICK_NS);
    localparam logic [11:0] MR_MIN_CYC = 12'((MR_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam int WDI_PULSE_CYC = (WDI_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // synchroniser bit positions and reset value
    // ------------------------------------------------------------
    localparam int SY_MR = 0;
    localparam int SY_MODE = 1;
    localparam int SY_VRST = 2;
    localparam int SY_VLL = 3;
    localparam int SY_XRST = 4;
    localparam int SY_XLL = 5;
    localparam int SY_WDI = 6;
    localparam int SY_OV = 7;
    localparam int SY_W = 8;
    localparam logic [SY_W-1:0] SYNC_RST = 8'h01; // manual reset idles high

    // ------------------------------------------------------------
    // reset sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RS_ACTIVE = 2'b01,
        RS_STRETCH = 2'b11,
        RS_RUN = 2'b10
    } rst_state_t;

endpackage

// file: core/timer_if.sv
/*
 * control and status of one tick-based timeout counter.
 * assumes the counter and its user share sys_clk.
 */
interface timer_if;
    logic clr;
    logic en;
    logic [sup_pkg::TW-1:0] limit;
    logic done;

    modport ctl (output clr, output en, output limit, input done);
    modport tmr (input clr, input en, input limit, output done);
endinterface

// file: core/sync2.sv
/*
 * two-flop synchroniser for a vector of independent levels.
 * assumes each bit is a slow level; no bus coherence is given.
 */
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

// file: core/tick_timer.sv
/*
 * saturating counter of time-base ticks, with a done flag at the limit.
 * assumes tick is a one-cycle pulse from the shared prescaler.
 */
module tick_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // time base
    input wire logic tick,
    // control
    timer_if.tmr t
);
    import sup_pkg::*;

    logic [TW-1:0] count_ff;
    logic [TW-1:0] nxt_count;
    logic at_limit;

    // saturates so done stays up until cleared
    assign at_limit = (count_ff >= t.limit);
    assign nxt_count = t.clr ? '0 : ((t.en && tick && !at_limit) ? count_ff + 1'b1 : count_ff);
    assign t.done = at_limit;

    // count advances on the shared tick only
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            count_ff <= '0;
        else
            count_ff <= nxt_count;
    end
endmodule

// file: verification/cpu_model.sv
/*
 * processor-side model: kicks the watchdog line and drives chip-select.
 * assumes the bench changes kick_en and ce_req at the falling edge;
 * a kick_en change may take effect one clock late.
 */
module cpu_model (
    // clock
    input wire logic sys_clk,
    // control from the bench
    input wire logic kick_en,
    input wire logic ce_req,
    // lines to the supervisor
    output logic wd_activity_in,
    output logic ce_in_n
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt = 0;

    initial wd_activity_in = 1'b0;

    // toggle every 500 clocks, well inside the shortest period;
    // first toggle lands at once so a re-enable clears a fault quickly
    always @(negedge sys_clk)
    begin
        if (!kick_en)
            cnt <= 0;
        else
        begin
            cnt <= (cnt == 499) ? 0 : cnt + 1;
            if (cnt == 0)
                wd_activity_in <= ~wd_activity_in;
        end
    end

    // a stalled processor simply stops kicking; chip-select is a plain level
    assign ce_in_n = ~ce_req;
endmodule

// file: verification/tb_supply_supervisor_reset_watchdog.sv
/*
 * self-checking bench for the supply supervisor, shortened timeouts.
 * assumes cpu_model beside it; one tick is 100 clocks.
 */
module tb_supply_supervisor_reset_watchdog;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk, srst, mode_ext_sense, vcc_below_reset, vcc_below_early_warning_n;
    logic ext_reset_below, early_warning_n_sense_in, manual_reset_n, wd_period_select;
    logic overvoltage_sense, kick_en, ce_req, wd_activity_in, ce_in_n;
    logic ce_out_n, ce_in_float, reset_n, reset_out, early_warning_n;
    logic overvoltage_flag_n, wd_fault_n, wd_pulse_n;
    logic [7:0] obs;
    int n_errors = 0;
    int comparisons = 0;
    localparam int RN = 0, EW = 2, OV = 3, FT = 4, PU = 5, CO = 6, CF = 7;

    // observed outputs gathered so waits can index them
    assign obs = {ce_in_float, ce_out_n, wd_pulse_n, wd_fault_n,
                  overvoltage_flag_n, early_warning_n, reset_out, reset_n};

    supply_supervisor_reset_watchdog #(.STRETCH_TICKS(24'h000014),
        .WD_TICKS(24'h00001e), .WD_ALT_TICKS(24'h00000f)) i_supply_supervisor_reset_watchdog (
        .sys_clk(sys_clk), .srst(srst), .mode_ext_sense(mode_ext_sense),
        .vcc_below_reset(vcc_below_reset), .vcc_below_early_warning_n(vcc_below_early_warning_n),
        .ext_reset_below(ext_reset_below), .early_warning_n_sense_in(early_warning_n_sense_in),
        .manual_reset_n(manual_reset_n), .wd_activity_in(wd_activity_in),
        .wd_period_select(wd_period_select), .overvoltage_sense(overvoltage_sense),
        .ce_in_n(ce_in_n), .ce_out_n(ce_out_n), .ce_in_float(ce_in_float),
        .reset_n(reset_n), .reset_out(reset_out), .early_warning_n(early_warning_n),
        .overvoltage_flag_n(overvoltage_flag_n), .wd_fault_n(wd_fault_n),
        .wd_pulse_n(wd_pulse_n));

    cpu_model i_cpu_model (.sys_clk(sys_clk), .kick_en(kick_en), .ce_req(ce_req),
        .wd_activity_in(wd_activity_in), .ce_in_n(ce_in_n));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    // every cycle walked also watches the complementary pair
    task automatic cyc(int n);
        repeat (n)
        begin
            @(negedge sys_clk);
            if (reset_out !== ~reset_n)
                check("reset_out", ~reset_n, reset_out);
        end
    endtask

    // change must land no sooner than lo and no later than hi cycles
    task automatic wait_val(int k, logic v, int lo, int hi, string name);
        int n;
        n = 0;
        while (obs[k] !== v && n < hi)
        begin
            cyc(1);
            n++;
        end
        if (obs[k] !== v)
        begin
            check(name, v, obs[k]);
            end_of_test();
        end
        check(name, 1'b1, n >= lo);
    endtask

    task automatic hold(int k, logic v, int n, string name);
        repeat (n)
        begin
            cyc(1);
            if (obs[k] !== v)
                break;
        end
        check(name, v, obs[k]);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        check("reset_n", 1'b0, reset_n);
        check("wd_outputs", 1'b1, wd_fault_n & wd_pulse_n);
        check("ce_in_float", 1'b1, ce_in_float);
        wait_val(RN, 1'b1, 1900, 2300, "stretch");
        ce_req = 1'b1;
        cyc(1);
        check("ce_out_n", 1'b0, ce_out_n);
        ce_req = 1'b0;
        cyc(1);
        check("ce_out_n", 1'b1, ce_out_n);
    endtask

    task automatic t_supply_fall();
        ce_req = 1'b1;
        vcc_below_early_warning_n = 1'b1;
        wait_val(EW, 1'b0, 1, 6, "warning");
        check("reset_n", 1'b1, reset_n);
        vcc_below_reset = 1'b1;
        wait_val(RN, 1'b0, 1, 6, "reset_low");
        check("ce_out_n", 1'b0, ce_out_n);
        wait_val(CO, 1'b1, 1350, 1700, "ce_hold");
        check("ce_in_float", 1'b1, ce_in_float);
        ce_req = 1'b0;
        cyc(2);
        ce_req = 1'b1;
        cyc(2);
        check("ce_blocked", 1'b1, ce_out_n);
        ce_req = 1'b0;
        vcc_below_reset = 1'b0;
        hold(RN, 1'b0, 1800, "stretch_hold");
        check("wd_outputs", 1'b1, wd_fault_n & wd_pulse_n);
        wait_val(RN, 1'b1, 1, 400, "stretch_end");
        vcc_below_early_warning_n = 1'b0;
        wait_val(EW, 1'b1, 1, 6, "warning_idle");
    endtask

    task automatic t_ext_mode();
        mode_ext_sense = 1'b1;
        cyc(4);
        vcc_below_reset = 1'b1;
        vcc_below_early_warning_n = 1'b1;
        hold(RN, 1'b1, 50, "ext_ignores_vcc");
        check("early_warning_n", 1'b1, early_warning_n);
        vcc_below_reset = 1'b0;
        vcc_below_early_warning_n = 1'b0;
        early_warning_n_sense_in = 1'b1;
        wait_val(EW, 1'b0, 1, 6, "ext_warning");
        ext_reset_below = 1'b1;
        wait_val(RN, 1'b0, 1, 6, "ext_reset");
        ext_reset_below = 1'b0;
        early_warning_n_sense_in = 1'b0;
        mode_ext_sense = 1'b0;
        wait_val(RN, 1'b1, 1900, 2300, "ext_stretch");
    endtask

    task automatic t_manual();
        manual_reset_n = 1'b0;
        cyc(1000);
        manual_reset_n = 1'b1;
        hold(RN, 1'b1, 2000, "short_press");
        manual_reset_n = 1'b0;
        // twelve ticks counted from a free-running tick: 11 to 12 us plus sync
        wait_val(RN, 1'b0, 1100, 1250, "mr_latency");
        hold(RN, 1'b0, 3000, "mr_held");
        manual_reset_n = 1'b1;
        wait_val(RN, 1'b1, 1900, 2300, "mr_stretch");
    endtask

    task automatic t_overvoltage();
        overvoltage_sense = 1'b1;
        wait_val(OV, 1'b0, 1, 6, "ov_low");
        check("reset_warn", 1'b1, reset_n & early_warning_n);
        overvoltage_sense = 1'b0;
        wait_val(OV, 1'b1, 1, 6, "ov_high");
    endtask

    task automatic t_watchdog();
        hold(FT, 1'b1, 4000, "kicked");
        wd_period_select = 1'b0;
        kick_en = 1'b0;
        wait_val(PU, 1'b0, 900, 1700, "alt_period");
        check("fault_after_pulse", 1'b1, wd_fault_n);
        cyc(1);
        check("wd_fault_n", 1'b0, wd_fault_n);
        vcc_below_reset = 1'b1;
        wait_val(PU, 1'b1, 1, 6, "wd_clear");
        check("wd_fault_n", 1'b1, wd_fault_n);
        vcc_below_reset = 1'b0;
        wd_period_select = 1'b1;
        wait_val(RN, 1'b1, 1900, 2300, "wd_stretch");
        wait_val(PU, 1'b0, 2900, 3300, "period");
        cyc(1);
        hold(FT, 1'b0, 200, "fault_level");
        kick_en = 1'b1;
        wait_val(FT, 1'b1, 1, 8, "fault_clear");
        check("pulse_width", 1'b0, wd_pulse_n);
    endtask

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // inputs idle inactive; the processor kicks from the start
    initial
    begin
        srst = 1'b1;
        {mode_ext_sense, vcc_below_reset, vcc_below_early_warning_n} = 3'h0;
        {ext_reset_below, early_warning_n_sense_in, overvoltage_sense, ce_req} = 4'h0;
        {manual_reset_n, wd_period_select, kick_en} = 3'h7;
        cyc(2);
        srst = 1'b0;
        t_power_up();
        t_supply_fall();
        t_ext_mode();
        t_manual();
        t_overvoltage();
        t_watchdog();
        end_of_test();
    end
endmodule
